// *** temp_event_defines.svh ***
// Constants for the module temperature event monitor: register pointers, field
// positions, reset values and hysteresis steps. Definitions only.
// How it works
// - Sensor samples are latched continuously unless shut down, and returned on serial reads at pointer five.
// - One open-drain alert pin belongs to the temperature sensor alone.
// - Alert supports interrupt, comparator and critical-only behaviour, host selected.
// - Host writes configuration at pointer one; hysteresis and mode steer alert logic.
// - Host loads upper and lower window limits; each reading is compared to both.
// - With window enabled, alert asserts above upper or below lower limit.
// - Interrupt behaviour holds alert until software clears it via configuration.
// - Comparator behaviour ignores clears; alert drops when temperature is back inside.
// - Critical-only asserts only above critical limit, comparator style, not clearable.
// - Mode bit zero: clear is comparator, set is interrupt; locked while any lock set.
`ifndef TEMP_EVENT_DEFINES_SVH
`define TEMP_EVENT_DEFINES_SVH

`define PTR_CAPABILITY 3'h0
`define PTR_CONFIG     3'h1
`define PTR_UPPER      3'h2
`define PTR_LOWER      3'h3
`define PTR_CRITICAL   3'h4
`define PTR_TEMP       3'h5

`define CAPABILITY_VAL 16'h0001
`define CONFIG_RST     16'h0000
`define LIMIT_RST      16'h0000
`define CONFIG_KEEP    16'h07cf

`define CFG_MODE       0
`define CFG_POLARITY   1
`define CFG_CRIT_ONLY  2
`define CFG_OUT_EN     3
`define CFG_STATUS     4
`define CFG_CLEAR      5
`define CFG_ALARM_LOCK 6
`define CFG_CRIT_LOCK  7
`define CFG_SHUTDOWN   8
`define CFG_HYST_LO    9
`define CFG_HYST_HI    10

// Hysteresis in 0.0625 degree steps: 1.5, 3 and 6 degrees
`define HYST_STEP1     13'h0018
`define HYST_STEP2     13'h0030
`define HYST_STEP3     13'h0060

`define SLAVE_BASE     4'h3

`endif

// *** temp_event_pkg.sv ***
// Types shared by the temperature event monitor.
// Assumes the defines header is compiled alongside.
package temp_event_pkg;
   typedef enum logic [2:0] {
      BUS_IDLE,
      BUS_RX,
      BUS_ACK,
      BUS_TX,
      BUS_MACK
   } bus_state_t;
endpackage

// *** alert_engine.sv ***
// Alert evaluation: window and critical comparisons with hysteresis, the three
// behaviours, and the registered open-drain alert pin.
// Assumes limits and reading share the same signed 13-bit format.
`timescale 1ns/10ps
`include "temp_event_defines.svh"
module alert_engine
   import temp_event_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic [12:0] temp,
   input  wire logic [12:0] upper,
   input  wire logic [12:0] lower,
   input  wire logic [12:0] crit,
   input  wire logic        int_mode,
   input  wire logic        crit_only,
   input  wire logic        out_en,
   input  wire logic        polarity,
   input  wire logic [1:0]  hyst,
   input  wire logic        clear_evt,
   output logic             asserted,
   output logic             event_o,
   output logic             event_oe
);
   logic               win_q;
   logic               crit_q;
   logic               irq_q;
   logic signed [12:0] t_s;
   logic signed [12:0] up_s;
   logic signed [12:0] lo_s;
   logic signed [12:0] cr_s;
   logic signed [12:0] hyst_s;
   logic               win_set;
   logic               win_rel;
   logic               crit_set;
   logic               crit_rel;
   logic               irq_d;
   logic               event_d;

   assign t_s      = temp;
   assign up_s     = upper;
   assign lo_s     = lower;
   assign cr_s     = crit;
   assign hyst_s   = (hyst == 2'h0) ? 13'h0000 :
                     (hyst == 2'h1) ? `HYST_STEP1 :
                     (hyst == 2'h2) ? `HYST_STEP2 : `HYST_STEP3;
   assign win_set  = (t_s > up_s) || (t_s < lo_s);
   assign win_rel  = (t_s <= up_s - hyst_s) && (t_s >= lo_s + hyst_s);
   assign crit_set = t_s > cr_s;
   assign crit_rel = t_s <= cr_s - hyst_s;
   // New window crossing latches; a clear in the same cycle loses to it
   assign irq_d    = (win_set && !win_q) || (irq_q && !clear_evt);
   assign event_d  = crit_only ? crit_q :
                     int_mode  ? (irq_q || crit_q) : (win_q || crit_q);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         win_q  <= 1'b0;
         crit_q <= 1'b0;
         irq_q  <= 1'b0;
      end else begin
         win_q  <= win_set || (win_q && !win_rel);
         crit_q <= crit_set || (crit_q && !crit_rel);
         irq_q  <= irq_d;
      end
   end

   // Pin is pulled low when active with low polarity, or idle with high polarity
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         asserted <= 1'b0;
         event_o  <= 1'b0;
         event_oe <= 1'b0;
      end else begin
         asserted <= out_en && event_d;
         event_o  <= 1'b0;
         event_oe <= (out_en && event_d) ^ polarity;
      end
   end
endmodule

// *** temp_event_monitor.sv ***
// Top of the temperature event monitor: serial-bus slave with pointer and
// 16-bit registers, sample capture, and the alert engine.
// Assumes scl/sda inputs are already synchronous to sys_clk and filtered.
`timescale 1ns/10ps
`include "temp_event_defines.svh"
module temp_event_monitor
   import temp_event_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic [2:0]  addr_pins,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   input  wire logic [12:0] temp_sample,
   input  wire logic        temp_valid,
   output logic             event_o,
   output logic             event_oe
);
   bus_state_t  state_q;
   logic        scl_q;
   logic        sda_q;
   logic [3:0]  cnt_q;
   logic [7:0]  shift_q;
   logic [1:0]  idx_q;
   logic        rw_q;
   logic        tx_lo_q;
   logic [2:0]  ptr_q;
   logic [7:0]  hi_q;
   logic [15:0] cfg_q;
   logic [15:0] upper_q;
   logic [15:0] lower_q;
   logic [15:0] crit_q;
   logic [15:0] temp_q;
   logic        asserted;

   logic        scl_rise;
   logic        scl_fall;
   logic        bus_start;
   logic        bus_stop;
   logic        byte_done;
   logic        addr_hit;
   logic        read_go;
   logic        reg_wr;
   logic [15:0] wdata;
   logic [15:0] rd_data;
   logic        locked;
   logic [15:0] cfg_d;
   logic        clear_evt;

   assign scl_rise  = scl_i && !scl_q;
   assign scl_fall  = !scl_i && scl_q;
   assign bus_start = scl_i && scl_q && sda_q && !sda_i;
   assign bus_stop  = scl_i && scl_q && !sda_q && sda_i;
   assign byte_done = (state_q == BUS_RX) && scl_fall && (cnt_q == 4'h8);
   assign addr_hit  = shift_q[7:1] == {`SLAVE_BASE, addr_pins};
   assign read_go   = rw_q && (idx_q == 2'h1);
   assign reg_wr    = byte_done && (idx_q == 2'h3) && !rw_q;
   assign wdata     = {hi_q, shift_q};

   assign rd_data = (ptr_q == `PTR_CAPABILITY) ? `CAPABILITY_VAL :
                    (ptr_q == `PTR_CONFIG)     ? (cfg_q | {11'h000, asserted, 4'h0}) :
                    (ptr_q == `PTR_UPPER)      ? upper_q :
                    (ptr_q == `PTR_LOWER)      ? lower_q :
                    (ptr_q == `PTR_CRITICAL)   ? crit_q :
                    (ptr_q == `PTR_TEMP)       ? temp_q : 16'h0000;

   // Lock bits are sticky; mode bit is frozen while any lock is set
   assign locked = cfg_q[`CFG_ALARM_LOCK] || cfg_q[`CFG_CRIT_LOCK];
   assign cfg_d  = (wdata & `CONFIG_KEEP & ~16'h0001)
                 | {8'h00, cfg_q[`CFG_CRIT_LOCK], cfg_q[`CFG_ALARM_LOCK], 6'h00}
                 | {15'h0000, locked ? cfg_q[`CFG_MODE] : wdata[`CFG_MODE]};
   assign clear_evt = reg_wr && (ptr_q == `PTR_CONFIG) && wdata[`CFG_CLEAR];

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_i;
         sda_q <= sda_i;
      end
   end

   // Serial-bus slave: receive address, pointer and data; transmit high and low bytes in turn until the host does not acknowledge
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= BUS_IDLE;
         cnt_q   <= 4'h0;
         shift_q <= 8'h00;
         idx_q   <= 2'h0;
         tx_lo_q <= 1'b0;
         sda_oe  <= 1'b0;
      end else if (bus_start) begin
         state_q <= BUS_RX;
         cnt_q   <= 4'h0;
         idx_q   <= 2'h0;
         sda_oe  <= 1'b0;
      end else if (bus_stop) begin
         state_q <= BUS_IDLE;
         sda_oe  <= 1'b0;
      end else begin
         case (state_q)
            BUS_RX: begin
               if (scl_rise) begin
                  shift_q <= {shift_q[6:0], sda_i};
                  cnt_q   <= cnt_q + 4'h1;
               end else if (byte_done) begin
                  idx_q <= (idx_q == 2'h3) ? 2'h2 : idx_q + 2'h1;
                  if (idx_q == 2'h0 && !addr_hit) begin
                     state_q <= BUS_IDLE;
                  end else begin
                     state_q <= BUS_ACK;
                     sda_oe  <= 1'b1;
                  end
               end
            end
            BUS_ACK: begin
               if (scl_fall) begin
                  cnt_q <= read_go ? 4'h1 : 4'h0;
                  if (read_go) begin
                     state_q <= BUS_TX;
                     shift_q <= {rd_data[14:8], 1'b0};
                     sda_oe  <= !rd_data[15];
                     tx_lo_q <= 1'b1;
                  end else begin
                     state_q <= BUS_RX;
                     sda_oe  <= 1'b0;
                  end
               end
            end
            BUS_TX: begin
               if (scl_fall) begin
                  if (cnt_q == 4'h8) begin
                     state_q <= BUS_MACK;
                     sda_oe  <= 1'b0;
                  end else begin
                     sda_oe  <= !shift_q[7];
                     shift_q <= {shift_q[6:0], 1'b0};
                     cnt_q   <= cnt_q + 4'h1;
                  end
               end
            end
            BUS_MACK: begin
               if (scl_rise && sda_i) begin
                  state_q <= BUS_IDLE;
               end else if (scl_fall) begin
                  state_q <= BUS_TX;
                  cnt_q   <= 4'h1;
                  tx_lo_q <= !tx_lo_q;
                  sda_oe  <= tx_lo_q ? !rd_data[7] : !rd_data[15];
                  shift_q <= tx_lo_q ? {rd_data[6:0], 1'b0} : {rd_data[14:8], 1'b0};
               end
            end
            default: begin
               state_q <= BUS_IDLE;
            end
         endcase
      end
   end

   // Protocol side registers: direction, pointer, high data byte, open-drain data
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rw_q  <= 1'b0;
         ptr_q <= `PTR_CAPABILITY;
         hi_q  <= 8'h00;
         sda_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
         if (byte_done && idx_q == 2'h0) begin
            rw_q <= shift_q[0];
         end
         if (byte_done && idx_q == 2'h1) begin
            ptr_q <= shift_q[2:0];
         end
         if (byte_done && idx_q == 2'h2) begin
            hi_q <= shift_q;
         end
      end
   end

   // Register file; limit writes are refused while their lock is set
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q   <= `CONFIG_RST;
         upper_q <= `LIMIT_RST;
         lower_q <= `LIMIT_RST;
         crit_q  <= `LIMIT_RST;
      end else if (reg_wr) begin
         if (ptr_q == `PTR_CONFIG) begin
            cfg_q <= cfg_d;
         end
         if (ptr_q == `PTR_UPPER && !cfg_q[`CFG_ALARM_LOCK]) begin
            upper_q <= wdata;
         end
         if (ptr_q == `PTR_LOWER && !cfg_q[`CFG_ALARM_LOCK]) begin
            lower_q <= wdata;
         end
         if (ptr_q == `PTR_CRITICAL && !cfg_q[`CFG_CRIT_LOCK]) begin
            crit_q <= wdata;
         end
      end
   end

   // Continuous sampling unless shut down
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         temp_q <= 16'h0000;
      end else if (temp_valid && !cfg_q[`CFG_SHUTDOWN]) begin
         temp_q <= {{3{temp_sample[12]}}, temp_sample};
      end
   end

   alert_engine u_alert (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .temp      (temp_q[12:0]),
      .upper     (upper_q[12:0]),
      .lower     (lower_q[12:0]),
      .crit      (crit_q[12:0]),
      .int_mode  (cfg_q[`CFG_MODE]),
      .crit_only (cfg_q[`CFG_CRIT_ONLY]),
      .out_en    (cfg_q[`CFG_OUT_EN]),
      .polarity  (cfg_q[`CFG_POLARITY]),
      .hyst      (cfg_q[`CFG_HYST_HI:`CFG_HYST_LO]),
      .clear_evt (clear_evt),
      .asserted  (asserted),
      .event_o   (event_o),
      .event_oe  (event_oe)
   );
endmodule

// *** temp_event_monitor_properties.sv ***
// Port checker for the temperature event monitor, bound to its top.
// Assumes serial clock phases of at least six system clocks.
`timescale 1ns/10ps
module temp_event_monitor_properties (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic temp_valid,
   input wire logic event_o,
   input wire logic event_oe
);
   logic [3:0] cause_q;
   // Cycles since the last sample pulse or serial clock low
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) cause_q <= 4'h0;
      else if (temp_valid || !scl_i) cause_q <= 4'h0;
      else if (cause_q != 4'hf) cause_q <= cause_q + 4'h1;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_after_fall;
      !scl_i && ($past(scl_i, 2) || $past(scl_i, 3) || $past(scl_i, 4));
   endsequence
   sequence s_quiet;
      (!event_oe && !sda_oe) [*2];
   endsequence
   a_event_drive_low: assert property (event_o == 1'b0)
      else $error("alert drive value not low");
   a_sda_drive_low: assert property (sda_o == 1'b0)
      else $error("data drive value not low");
   a_reset_quiet: assert property ($rose(rst_n) |-> s_quiet)
      else $error("pins driven after reset");
   a_sda_rise_late: assert property ($rose(sda_oe) |-> s_after_fall)
      else $error("data pull began outside clock low");
   a_sda_fall_late: assert property ($fell(sda_oe) |-> s_after_fall)
      else $error("data release outside clock low");
   a_sda_steady_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
      else $error("data changed while clock high");
   a_start_no_pull: assert property (scl_i && $past(scl_i) && $fell(sda_i) |-> !sda_oe)
      else $error("device pulled data at start");
   a_event_has_cause: assert property ($changed(event_oe) |-> cause_q < 4'h6)
      else $error("alert moved without a cause");
   c_event_rise: cover property ($rose(event_oe));
endmodule
bind temp_event_monitor temp_event_monitor_properties chk (
   .sys_clk(sys_clk), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe(sda_oe), .temp_valid(temp_valid),
   .event_o(event_o), .event_oe(event_oe));

// *** smbus_host_model.sv ***
// Serial bus host model: bit-level master with register access tasks.
// Assumes the bench resolves the pulled-up data wire.
`timescale 1ns/10ps
module smbus_host_model (
   input  wire logic sys_clk,
   input  wire logic sda_w,
   output logic      scl,
   output logic      sda_low
);
   localparam int Q = 6;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic tick();
      repeat (Q) @(posedge sys_clk);
      #1;
   endtask
   task automatic start();
      sda_low = 1'b0;
      tick();
      scl = 1'b1;
      tick();
      sda_low = 1'b1;
      tick();
      scl = 1'b0;
   endtask
   task automatic stop();
      sda_low = 1'b1;
      tick();
      scl = 1'b1;
      tick();
      sda_low = 1'b0;
      tick();
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_low = !b;
      tick();
      scl = 1'b1;
      tick();
      r = sda_w;
      scl = 1'b0;
   endtask
   // Ack bit: 1 releases the wire, result is high when pulled low
   task automatic byte_io(input logic [7:0] d, input logic ai, output logic [7:0] q,
                          output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(ai, ack);
      ack = !ack;
   endtask
   task automatic wr_reg(input logic [6:0] a, input logic [2:0] p, input logic [15:0] d,
                         output logic [3:0] k);
      logic [7:0] q;
      start();
      byte_io({a, 1'b0}, 1'b1, q, k[3]);
      byte_io({5'h00, p}, 1'b1, q, k[2]);
      byte_io(d[15:8], 1'b1, q, k[1]);
      byte_io(d[7:0], 1'b1, q, k[0]);
      stop();
   endtask
   task automatic rd_reg(input logic [6:0] a, input logic [2:0] p, output logic [15:0] d,
                         output logic [3:0] k);
      logic [7:0] q;
      start();
      byte_io({a, 1'b0}, 1'b1, q, k[3]);
      byte_io({5'h00, p}, 1'b1, q, k[2]);
      start();
      byte_io({a, 1'b1}, 1'b1, q, k[1]);
      byte_io(8'hff, 1'b0, d[15:8], k[0]);
      byte_io(8'hff, 1'b1, d[7:0], q[0]);
      stop();
   endtask
endmodule

// *** test_module_temp_event_monitor.sv ***
// Self-checking bench for the temperature event monitor with a host model.
// Assumes the checker file is compiled and bound to the top.
`timescale 1ns/10ps
module test_module_temp_event_monitor;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [2:0]  addr_pins = 3'h0;
   logic [12:0] temp_sample = 13'h0000;
   logic        temp_valid = 1'b0;
   logic        scl, sda_low, sda_o, sda_oe, event_o, event_oe;
   wire         sda_w = !(sda_oe | sda_low);
   int          seed = 9;
   int          errors = 0;
   int          num_checks = 0;
   logic [6:0]  dev;
   logic [15:0] rd;
   logic [3:0]  k;
   logic [12:0] up, lo, t;
   logic [12:0] cs [4] = '{13'h0200, 13'h0201, 13'h00ff, 13'h0100};
   always #25 sys_clk = !sys_clk;
   temp_event_monitor dut (.sys_clk(sys_clk), .rst_n(rst_n), .addr_pins(addr_pins),
      .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
      .temp_sample(temp_sample), .temp_valid(temp_valid),
      .event_o(event_o), .event_oe(event_oe));
   smbus_host_model host (.sys_clk(sys_clk), .sda_w(sda_w), .scl(scl), .sda_low(sda_low));
   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic cmp1(input logic g, input logic e);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [2:0] p, input logic [15:0] d);
      host.wr_reg(dev, p, d, k);
      cmp16({12'h000, k}, 16'h000f);
   endtask
   task automatic rdc(input logic [2:0] p, input logic [15:0] e);
      host.rd_reg(dev, p, rd, k);
      cmp16(rd, e);
   endtask
   task automatic feed(input logic [12:0] v);
      @(posedge sys_clk);
      #1;
      temp_sample = v;
      temp_valid = 1'b1;
      @(posedge sys_clk);
      #1;
      temp_valid = 1'b0;
      repeat (5) @(posedge sys_clk);
      #1;
   endtask
   function automatic logic outside(input logic [12:0] v);
      return $signed(v) > $signed(up) || $signed(v) < $signed(lo);
   endfunction
   initial begin
      addr_pins = 3'($random(seed));
      dev = {4'h3, addr_pins};
      repeat (16) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      repeat (2) @(posedge sys_clk);
      for (int i = 0; i < 7; i++) rdc(3'(i), (i == 0) ? 16'h0001 : 16'h0000);
      host.wr_reg(dev ^ 7'h01, 3'h1, 16'h0008, k);
      cmp16({12'h000, k}, 16'h0000);
      // Critical limit above every window sample, so only the window steers the pin
      wr(3'h4, 16'h0400);
      rdc(3'h4, 16'h0400);
      up = 13'h0200;
      lo = 13'h0100;
      wr(3'h2, {3'h0, up});
      wr(3'h3, {3'h0, lo});
      wr(3'h1, 16'h0008);
      for (int n = 0; n < 16; n++) begin
         t = (n < 4) ? cs[n] : 13'h0080 + 13'($random(seed) & 32'h1ff);
         feed(t);
         cmp1(event_oe, outside(t));
      end
      rdc(3'h5, {{3{t[12]}}, t});
      feed(13'h0300);
      wr(3'h1, 16'h0028);
      cmp1(event_oe, 1'b1);
      feed(13'h0180);
      cmp1(event_oe, 1'b0);
      wr(3'h1, 16'h0009);
      feed(13'h0300);
      feed(13'h0180);
      cmp1(event_oe, 1'b1);
      rdc(3'h1, 16'h0019);
      wr(3'h1, 16'h0029);
      cmp1(event_oe, 1'b0);
      wr(3'h1, 16'h0208);
      feed(13'h0210);
      feed(13'h01f0);
      cmp1(event_oe, 1'b1);
      feed(13'h01e0);
      cmp1(event_oe, 1'b0);
      wr(3'h4, 16'h0400);
      wr(3'h1, 16'h000c);
      feed(13'h0300);
      cmp1(event_oe, 1'b0);
      feed(13'h0401);
      wr(3'h1, 16'h002c);
      cmp1(event_oe, 1'b1);
      feed(13'h0300);
      cmp1(event_oe, 1'b0);
      wr(3'h1, 16'h000a);
      feed(13'h0300);
      cmp1(event_oe, 1'b0);
      feed(13'h0180);
      cmp1(event_oe, 1'b1);
      wr(3'h1, 16'h0049);
      wr(3'h1, 16'h0048);
      rdc(3'h1, 16'h0049);
      wr(3'h2, 16'h0050);
      rdc(3'h2, 16'h0200);
      report_and_stop();
   end
   initial begin
      repeat (90000) @(posedge sys_clk);
      errors++;
      report_and_stop();
   end
endmodule
